// ### logic/hcs_command_status.sv
// Command and status register of a USB host controller operational bank.
// Assumes a simple same-clock register port and list walker signals.
// How it works
// - Overrun counter bits 17:16 count overruns.
// - Counter resets to zero, wraps after three.
// - Count even when overrun flag already set.
// - Ownership request sets status bit 30.
// - Changeover done clears request until next.
// - Bulk flag zero at head skips bulk.
// - Bulk flag one starts list, clears flag.
// - Found bulk descriptor sets flag again.
// - Empty bulk pass stops bulk processing.
// - Control flag zero at head skips list.
// - Control flag one starts list, clears flag.
// - Found control descriptor sets flag again.
// - Empty control pass stops control processing.
// - Soft reset enters suspend, clears operational registers.
// - Routing bit kept; no bus accesses.
// - Hardware clears reset bit when done.
// - Soft reset finishes within ten microseconds.
// - Soft reset leaves root hub, ports alone.
// - Command writes set ones, ignore zeros.
// - Periodic list unfinished at frame end overruns.
// - Overrun increments counter and sets flag.
`timescale 1ns/10ps
`default_nettype none
module hcs_command_status #(
  parameter int SRST_CYCLES = hcs_pkg::SRST_WORK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire hcs_pkg::hcs_reg_req_t i_req,
  input wire logic i_eof,
  input wire logic i_periodic_busy,
  input wire hcs_pkg::hcs_list_ev_t i_bulk_ev,
  input wire hcs_pkg::hcs_list_ev_t i_ctrl_ev,
  input wire logic i_owner_done,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  output logic o_bulk_run,
  output logic o_ctrl_run,
  output logic o_so_flag,
  output logic o_own_flag,
  output logic o_suspended,
  output logic o_bus_quiet,
  output logic o_regs_reset,
  output logic o_routing
);
  // Register port write hit on one offset.
  function automatic logic wr_hit(input hcs_pkg::hcs_reg_req_t r,
                                  input logic [7:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction

  hcs_pkg::hcs_state_t state_q;
  logic [15:0] cnt_q;
  logic srst_cmd_q;
  logic own_req_q;
  logic own_req_prev_q;
  logic [1:0] soc_q;
  logic [1:0] soc_d;
  logic so_q;
  logic own_chg_q;
  logic routing_q;
  logic [1:0] fs_q;
  logic susp_q;
  logic quiet_q;
  logic regs_reset_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic rvalid_q;
  logic in_srst;
  logic wr_cs;
  logic wr_is;
  logic wr_ct;
  logic overrun;
  logic bulk_filled;
  logic ctrl_filled;
  logic bulk_run;
  logic ctrl_run;

  // While the soft reset runs, register writes are not accepted at all.
  assign in_srst = (state_q == hcs_pkg::ST_SRST);
  assign wr_cs = wr_hit(i_req, hcs_pkg::OFS_CMD_STATUS) && !in_srst;
  assign wr_is = wr_hit(i_req, hcs_pkg::OFS_INT_STATUS) && !in_srst;
  assign wr_ct = wr_hit(i_req, hcs_pkg::OFS_CONTROL) && !in_srst;

  // An overrun is the periodic list still busy when the frame ends.
  assign overrun = i_eof && i_periodic_busy && !in_srst;

  // Soft reset sequencer; the work window is far shorter than the limit.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= hcs_pkg::ST_RUN;
      cnt_q <= 16'h0000;
    end else if (i_ce) begin
      unique case (state_q)
        hcs_pkg::ST_RUN: begin
          cnt_q <= 16'h0000;
          if (wr_cs && i_req.wdata[hcs_pkg::CS_RESET_BIT]) begin
            state_q <= hcs_pkg::ST_SRST;
          end
        end
        hcs_pkg::ST_SRST: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(SRST_CYCLES - 1)) begin
            state_q <= hcs_pkg::ST_RUN;
          end
        end
        default: begin
          state_q <= hcs_pkg::ST_RUN;
        end
      endcase
    end
  end

  // The reset command bit reads one until the sequencer finishes.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      srst_cmd_q <= 1'b0;
    end else if (i_ce) begin
      if (!in_srst && wr_cs && i_req.wdata[hcs_pkg::CS_RESET_BIT]) begin
        srst_cmd_q <= 1'b1;
      end else if (in_srst && cnt_q == 16'(SRST_CYCLES - 1)) begin
        srst_cmd_q <= 1'b0;
      end
    end
  end

  // Host bus stays idle meanwhile; the register reset output pulses one cycle after the command write.
  // The root hub and port signalling have no link to this reset at all.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      quiet_q <= 1'b0;
      regs_reset_q <= 1'b0;
    end else if (i_ce) begin
      quiet_q <= (state_q == hcs_pkg::ST_SRST) ||
                 (wr_cs && i_req.wdata[hcs_pkg::CS_RESET_BIT]);
      regs_reset_q <= wr_cs && i_req.wdata[hcs_pkg::CS_RESET_BIT];
    end
  end

  // Ownership request: a written one sets it, changeover clears it.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      own_req_q <= 1'b0;
      own_req_prev_q <= 1'b0;
    end else if (i_ce) begin
      own_req_prev_q <= own_req_q;
      if (in_srst) begin
        own_req_q <= 1'b0;
      end else if (wr_cs && i_req.wdata[hcs_pkg::CS_OWN_REQ_BIT]) begin
        own_req_q <= 1'b1;
      end else if (i_owner_done) begin
        own_req_q <= 1'b0;
      end
    end
  end

  // Counter next value: set-only write first, then the overrun step.
  always_comb begin
    soc_d = soc_q;
    if (wr_cs) begin
      soc_d = soc_q | i_req.wdata[hcs_pkg::CS_OVR_HI:hcs_pkg::CS_OVR_LO];
    end
    if (overrun) begin
      soc_d = soc_d + 2'h1;
    end
  end

  // The counter steps regardless of the overrun flag state.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      soc_q <= hcs_pkg::OVR_RESET_VAL;
    end else if (i_ce) begin
      if (in_srst) begin
        soc_q <= hcs_pkg::OVR_RESET_VAL;
      end else begin
        soc_q <= soc_d;
      end
    end
  end

  // Sticky status flags clear on a written one; a new event wins.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      so_q <= 1'b0;
      own_chg_q <= 1'b0;
    end else if (i_ce) begin
      if (in_srst) begin
        so_q <= 1'b0;
        own_chg_q <= 1'b0;
      end else begin
        if (overrun) begin
          so_q <= 1'b1;
        end else if (wr_is && i_req.wdata[hcs_pkg::IS_OVERRUN_BIT]) begin
          so_q <= 1'b0;
        end
        if (own_req_q && !own_req_prev_q) begin
          own_chg_q <= 1'b1;
        end else if (wr_is && i_req.wdata[hcs_pkg::IS_OWN_CHANGE_BIT]) begin
          own_chg_q <= 1'b0;
        end
      end
    end
  end

  // Control register: the routing bit is exempt from soft reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      routing_q <= 1'b0;
      fs_q <= hcs_pkg::FS_RESET;
      susp_q <= 1'b0;
    end else if (i_ce) begin
      if (in_srst) begin
        fs_q <= hcs_pkg::FS_SUSPEND;
        susp_q <= 1'b1;
      end else if (wr_ct) begin
        routing_q <= i_req.wdata[hcs_pkg::CT_ROUTING_BIT];
        fs_q <= i_req.wdata[hcs_pkg::CT_FS_HI:hcs_pkg::CT_FS_LO];
        susp_q <= (i_req.wdata[hcs_pkg::CT_FS_HI:hcs_pkg::CT_FS_LO] ==
                   hcs_pkg::FS_SUSPEND);
      end
    end
  end

  // Bulk list gate; software sets the flag through the set-only write.
  hcs_list_gate u_bulk (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clear(in_srst),
    .i_sw_set(wr_cs && i_req.wdata[hcs_pkg::CS_BULK_FILLED_BIT]),
    .i_ev(i_bulk_ev),
    .o_filled(bulk_filled),
    .o_run(bulk_run)
  );

  // Control list gate; same behaviour as the bulk one.
  hcs_list_gate u_ctrl (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_clear(in_srst),
    .i_sw_set(wr_cs && i_req.wdata[hcs_pkg::CS_CTRL_FILLED_BIT]),
    .i_ev(i_ctrl_ev),
    .o_filled(ctrl_filled),
    .o_run(ctrl_run)
  );

  // Read data selection; unmapped offsets and reserved bits read zero.
  always_comb begin
    rdata_d = hcs_pkg::REG_RESET_VAL;
    unique case (i_req.addr)
      hcs_pkg::OFS_CMD_STATUS: begin
        rdata_d[hcs_pkg::CS_RESET_BIT] = srst_cmd_q;
        rdata_d[hcs_pkg::CS_CTRL_FILLED_BIT] = ctrl_filled;
        rdata_d[hcs_pkg::CS_BULK_FILLED_BIT] = bulk_filled;
        rdata_d[hcs_pkg::CS_OWN_REQ_BIT] = own_req_q;
        rdata_d[hcs_pkg::CS_OVR_HI:hcs_pkg::CS_OVR_LO] = soc_q;
      end
      hcs_pkg::OFS_INT_STATUS: begin
        rdata_d[hcs_pkg::IS_OVERRUN_BIT] = so_q;
        rdata_d[hcs_pkg::IS_OWN_CHANGE_BIT] = own_chg_q;
      end
      hcs_pkg::OFS_CONTROL: begin
        rdata_d[hcs_pkg::CT_ROUTING_BIT] = routing_q;
        rdata_d[hcs_pkg::CT_FS_HI:hcs_pkg::CT_FS_LO] = fs_q;
      end
      default: begin
        rdata_d = hcs_pkg::REG_RESET_VAL;
      end
    endcase
  end

  // Reads answer one cycle later, also during the soft reset.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdata_q <= hcs_pkg::REG_RESET_VAL;
      rvalid_q <= 1'b0;
    end else if (i_ce) begin
      rvalid_q <= i_req.rd;
      if (i_req.rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;
  assign o_bulk_run = bulk_run;
  assign o_ctrl_run = ctrl_run;
  assign o_so_flag = so_q;
  assign o_own_flag = own_chg_q;
  assign o_suspended = susp_q;
  assign o_bus_quiet = quiet_q;
  assign o_regs_reset = regs_reset_q;
  assign o_routing = routing_q;

  chk_ovr_count_step: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    overrun && !wr_cs |=> soc_q == 2'($past(soc_q) + 2'h1))
    else $error("overrun counter did not step by one");

  chk_ovr_count_wrap: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    overrun && !wr_cs && soc_q == 2'h3 |=> soc_q == 2'h0)
    else $error("overrun counter did not wrap to zero");

  chk_ovr_flag_set: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    overrun && so_q && !wr_cs |=> so_q && soc_q != $past(soc_q))
    else $error("counter held while flag already set");

  chk_overrun_flag: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    i_eof && i_periodic_busy && !in_srst |=> so_q)
    else $error("frame end overrun did not set flag");

  chk_own_change: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    $rose(own_req_q) && !in_srst |=> own_chg_q)
    else $error("ownership request did not raise flag");

  chk_own_clear: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    i_owner_done && !wr_cs |=> !own_req_q)
    else $error("changeover did not clear request");

  chk_set_only: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    wr_cs && own_req_q && !i_req.wdata[hcs_pkg::CS_OWN_REQ_BIT]
    && !i_owner_done |=> own_req_q)
    else $error("written zero cleared a command bit");

  chk_srst_bound: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    $rose(srst_cmd_q) |-> ##[1:1000] !srst_cmd_q)
    else $error("soft reset ran past its limit");

  chk_srst_suspend: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    in_srst |=> fs_q == hcs_pkg::FS_SUSPEND && soc_q == 2'h0)
    else $error("soft reset did not suspend and clear");

  chk_routing_kept: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    in_srst |=> routing_q == $past(routing_q) && quiet_q)
    else $error("routing bit changed or bus active in reset");

  chk_srst_done: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    $fell(in_srst) |-> !srst_cmd_q)
    else $error("reset bit still set after reset");
endmodule // hcs_command_status
`default_nettype wire

// ### logic/hcs_list_gate.sv
// Filled flag and run state for one non-periodic list.
// Assumes the list walker and register port share the clock.
`timescale 1ns/10ps
`default_nettype none
module hcs_list_gate (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_sw_set,
  input wire hcs_pkg::hcs_list_ev_t i_ev,
  output logic o_filled,
  output logic o_run
);
  logic filled_q;
  logic run_q;

  // Every set source wins over the clear taken at the list head.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      filled_q <= 1'b0;
    end else if (i_ce) begin
      if (i_clear) begin
        filled_q <= 1'b0;
      end else if (i_sw_set || (run_q && i_ev.td_found)) begin
        filled_q <= 1'b1;
      end else if (i_ev.at_head && filled_q) begin
        filled_q <= 1'b0;
      end
    end
  end

  // A pass stops only if nobody refilled the flag since the head.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
    end else if (i_ce) begin
      if (i_clear) begin
        run_q <= 1'b0;
      end else if (i_ev.at_head) begin
        run_q <= filled_q;
      end else if (i_ev.pass_end && !filled_q && !i_sw_set) begin
        run_q <= 1'b0;
      end
    end
  end

  assign o_filled = filled_q;
  assign o_run = run_q;

  chk_head_skip: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    i_ev.at_head && !filled_q && !i_clear |=> !run_q)
    else $error("list ran with filled flag clear");
  chk_head_take: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    i_ev.at_head && filled_q && !i_clear && !i_sw_set
    && !(run_q && i_ev.td_found) |=> run_q && !filled_q)
    else $error("list head did not start and clear");
  chk_td_refill: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    run_q && i_ev.td_found && !i_clear |=> filled_q)
    else $error("found descriptor did not set flag");
  chk_pass_stop: assert property (@(posedge i_clk)
    disable iff (!i_rst_n || !i_ce)
    i_ev.pass_end && !i_ev.at_head && !filled_q && !i_sw_set
    && !i_clear |=> !run_q)
    else $error("empty pass did not stop list");
endmodule // hcs_list_gate
`default_nettype wire

// ### pkg/hcs_pkg.sv
// Constants and carrier types for the command and status register block.
// Assumes one 100 MHz clock shared by the register port and list logic.
`default_nettype none
package hcs_pkg;
  // Register offsets within the operational register window.
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CMD_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_STATUS = 8'h0c;

  // Field positions of the command and status register.
  localparam int CS_RESET_BIT = 0;
  localparam int CS_CTRL_FILLED_BIT = 1;
  localparam int CS_BULK_FILLED_BIT = 2;
  localparam int CS_OWN_REQ_BIT = 3;
  localparam int CS_OVR_LO = 16;
  localparam int CS_OVR_HI = 17;

  // Field positions of the interrupt status and control registers.
  localparam int IS_OVERRUN_BIT = 0;
  localparam int IS_OWN_CHANGE_BIT = 30;
  localparam int CT_FS_LO = 6;
  localparam int CT_FS_HI = 7;
  localparam int CT_ROUTING_BIT = 8;

  // Reset values and functional state codes.
  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
  localparam logic [1:0] OVR_RESET_VAL = 2'h0;
  localparam logic [1:0] FS_RESET = 2'h0;
  localparam logic [1:0] FS_SUSPEND = 2'h3;

  // Software reset timing: the limit in ns and the cycles it allows.
  localparam int CLK_PERIOD_NS = 10;
  localparam int SRST_LIMIT_NS = 10000;
  localparam int SRST_MAX_CYCLES = SRST_LIMIT_NS / CLK_PERIOD_NS;
  localparam int SRST_WORK_CYCLES = 16;

  // One event group from a list walker.
  typedef struct packed {
    logic at_head;
    logic td_found;
    logic pass_end;
  } hcs_list_ev_t;

  // One register port request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } hcs_reg_req_t;

  // Soft reset sequencer states.
  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SRST = 2'b10
  } hcs_state_t;
endpackage
`default_nettype wire

// ### test/hcs_command_status_test.sv
// Self-checking bench for the command and status register block.
// Assumes hcs_driver_model issues the register cycles.
`timescale 1ns/10ps
`default_nettype none
module hcs_command_status_test;
  localparam int SRST = 16;
  logic i_clk, i_rst_n, i_ce, i_eof, i_periodic_busy, i_owner_done;
  hcs_pkg::hcs_reg_req_t req;
  hcs_pkg::hcs_list_ev_t bulk_ev, ctrl_ev;
  logic [31:0] rdata;
  logic rvalid, bulk_run, ctrl_run, so_flag, own_flag;
  logic suspended, bus_quiet, regs_reset, routing;
  int fails, compares;

  hcs_driver_model drv_u (.i_clk(i_clk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_req(req));

  hcs_command_status #(.SRST_CYCLES(SRST)) dut_u (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(req), .i_eof(i_eof),
    .i_periodic_busy(i_periodic_busy), .i_bulk_ev(bulk_ev),
    .i_ctrl_ev(ctrl_ev), .i_owner_done(i_owner_done), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_bulk_run(bulk_run), .o_ctrl_run(ctrl_run),
    .o_so_flag(so_flag), .o_own_flag(own_flag), .o_suspended(suspended),
    .o_bus_quiet(bus_quiet), .o_regs_reset(regs_reset),
    .o_routing(routing));

  // Free-running 100 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    drv_u.reg_write(a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    drv_u.reg_read(a, d);
    check(d, exp);
  endtask

  // One end-of-frame pulse; busy high makes it an overrun.
  task automatic frame_end(input logic busy);
    @(posedge i_clk);
    i_eof <= 1'b1;
    i_periodic_busy <= busy;
    @(posedge i_clk);
    i_eof <= 1'b0;
    i_periodic_busy <= 1'b0;
  endtask

  // One walker event group on the chosen list, one cycle wide.
  task automatic send_ev(input bit bulk, input logic [2:0] ev);
    @(posedge i_clk);
    if (bulk) bulk_ev <= ev;
    else ctrl_ev <= ev;
    @(posedge i_clk);
    bulk_ev <= '0;
    ctrl_ev <= '0;
    @(negedge i_clk);
  endtask

  task automatic t_reset_values;
    check({bulk_run, ctrl_run, so_flag, own_flag, suspended, bus_quiet,
      routing}, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'h0);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0);
    rd(8'h08, 32'h0);
    $display("test reset_values done");
  endtask

  task automatic t_ownership;
    wr(8'h08, 32'h8);
    @(posedge i_clk);
    @(negedge i_clk);
    check(own_flag, 32'h1);
    rd(8'h0c, 32'h4000_0000);
    rd(8'h08, 32'h8);
    @(posedge i_clk);
    i_owner_done <= 1'b1;
    @(posedge i_clk);
    i_owner_done <= 1'b0;
    rd(8'h08, 32'h0);
    repeat (4) @(posedge i_clk);
    rd(8'h08, 32'h0);
    wr(8'h0c, 32'h4000_0000);
    rd(8'h0c, 32'h0);
    $display("test ownership done");
  endtask

  // Bit 0 of the event is pass_end, bit 1 td_found, bit 2 at_head.
  task automatic t_list(input bit bulk);
    logic [31:0] fb;
    fb = bulk ? 32'h4 : 32'h2;
    send_ev(bulk, 3'b100);
    check(bulk ? bulk_run : ctrl_run, 32'h0);
    wr(8'h08, fb);
    send_ev(bulk, 3'b100);
    check(bulk ? bulk_run : ctrl_run, 32'h1);
    rd(8'h08, 32'h0);
    send_ev(bulk, 3'b010);
    rd(8'h08, fb);
    send_ev(bulk, 3'b001);
    check(bulk ? bulk_run : ctrl_run, 32'h1);
    send_ev(bulk, 3'b100);
    send_ev(bulk, 3'b001);
    check(bulk ? bulk_run : ctrl_run, 32'h0);
    $display("test list %0d done", bulk);
  endtask

  task automatic t_overrun;
    logic [1:0] n;
    n = 2'h0;
    frame_end(1'b0);
    rd(8'h08, 32'h0);
    for (int k = 0; k < 5; k++) begin
      frame_end(1'b1);
      n++;
      rd(8'h08, {14'h0, n, 16'h0});
    end
    check(so_flag, 32'h1);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h0);
    $display("test overrun done");
  endtask

  task automatic t_set_only;
    wr(8'h08, 32'h6);
    wr(8'h08, 32'h0);
    rd(8'h08, 32'h0001_0006);
    // An overrun while the enable is low must leave every bit frozen.
    @(posedge i_clk);
    i_ce <= 1'b0;
    frame_end(1'b1);
    @(posedge i_clk);
    i_ce <= 1'b1;
    rd(8'h08, 32'h0001_0006);
    check(so_flag, 32'h0);
    $display("test set_only done");
  endtask

  task automatic t_soft_reset;
    time t0;
    int n;
    wr(8'h04, 32'h100);
    wr(8'h08, 32'h1);
    t0 = $time;
    @(negedge i_clk);
    check(bus_quiet, 32'h1);
    check(regs_reset, 32'h1);
    wr(8'h08, 32'h4);
    @(negedge i_clk);
    check(regs_reset, 32'h0);
    n = 0;
    while (bus_quiet === 1'b1 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    n = int'(($time - t0) / 10);
    check(n, SRST + 1);
    check(n <= hcs_pkg::SRST_MAX_CYCLES, 32'h1);
    check({suspended, routing}, 32'h3);
    rd(8'h08, 32'h0);
    rd(8'h04, 32'h1c0);
    $display("test soft_reset done");
  endtask

  // Reset, then the scenarios in an order that keeps expectations exact.
  initial begin
    fails = 0;
    compares = 0;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_eof = 1'b0;
    i_periodic_busy = 1'b0;
    i_owner_done = 1'b0;
    bulk_ev = '0;
    ctrl_ev = '0;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    t_reset_values();
    t_ownership();
    t_list(1'b1);
    t_list(1'b0);
    t_overrun();
    t_set_only();
    t_soft_reset();
    stop_test();
  end

  // The scenarios need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge i_clk);
    fails++;
    stop_test();
  end
endmodule // hcs_command_status_test
`default_nettype wire

// ### test/hcs_driver_model.sv
// Driver software model that issues one-cycle register reads and writes.
// Assumes the block takes a request on a rising edge of i_clk.
`timescale 1ns/10ps
`default_nettype none
module hcs_driver_model (
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  output var hcs_pkg::hcs_reg_req_t o_req
);
  // Idle bus at time zero.
  initial begin
    o_req = '0;
  end

  // Commands reach the block only as written ones.
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    o_req.wr <= 1'b1;
    o_req.rd <= 1'b0;
    o_req.addr <= a;
    o_req.wdata <= d;
    @(posedge i_clk);
    // Released lines show the inverse so stale values cannot pass.
    o_req.wr <= 1'b0;
    o_req.addr <= ~a;
    o_req.wdata <= ~d;
  endtask

  // The answer stands one cycle, so it is taken at the following negedge.
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    o_req.wr <= 1'b0;
    o_req.rd <= 1'b1;
    o_req.addr <= a;
    @(posedge i_clk);
    o_req.rd <= 1'b0;
    o_req.addr <= ~a;
    @(negedge i_clk);
    d = (i_rvalid === 1'b1) ? i_rdata : 32'hxxxx_xxxx;
  endtask
endmodule // hcs_driver_model
`default_nettype wire
